// >>> rtl/mpa_top.sv
// monitor scaling and excess position error alarm
`timescale 1ns/1ps
`default_nettype none
module mpa_top (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               update_tick,
  input  wire logic [1:0]         control_mode,
  input  wire logic signed [31:0] position_reference,
  input  wire logic signed [31:0] actual_position,
  input  wire logic signed [23:0] torque_ref_mv,
  input  wire logic signed [23:0] motor_speed_mv,
  input  wire logic               positioning_done,
  input  wire logic [3:0]         monitor_one_signal_select,
  input  wire logic [3:0]         monitor_two_signal_select,
  input  wire logic               setting_write,
  input  wire logic [1:0]         setting_addr,
  input  wire logic signed [31:0] setting_data,
  input  wire logic               alarm_clear,
  output var  logic signed [23:0] monitor_one_mv,
  output var  logic signed [23:0] monitor_two_mv,
  output var  logic               monitor_one_linear,
  output var  logic               monitor_two_linear,
  output var  logic signed [31:0] position_error,
  output var  logic               excess_position_error_alarm,
  output var  logic               motor_stop
);
  ////////////////////////////////////////////////////////////////////
  // settings held in flops; writes outside range are ignored
  logic signed [15:0] monitor_one_offset_reg;
  logic signed [15:0] monitor_two_offset_reg;
  logic signed [15:0] monitor_magnification_reg;
  logic [31:0]        position_error_alarm_level_reg;
  logic [3:0]         sel_one_reg;
  logic [3:0]         sel_two_reg;
  logic               sel_loaded_reg;
  wire                in_range = (setting_data >= 32'(mpa_pkg::SET_MIN))
                              && (setting_data <= 32'(mpa_pkg::SET_MAX));
  wire                lvl_ok   = (setting_data >= 32'(mpa_pkg::ALARM_LEVEL_MIN))
                              && (setting_data <= 32'(mpa_pkg::ALARM_LEVEL_MAX));
  wire                wr_off1  = setting_write && setting_addr == 2'h0 && in_range;
  wire                wr_off2  = setting_write && setting_addr == 2'h1 && in_range;
  wire                wr_mag   = setting_write && setting_addr == 2'h2 && in_range;
  wire                wr_lvl   = setting_write && setting_addr == 2'h3 && lvl_ok;

  // setting storage; reset values are defaults
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      monitor_one_offset_reg         <= mpa_pkg::OFFSET_RESET;
      monitor_two_offset_reg         <= mpa_pkg::OFFSET_RESET;
      monitor_magnification_reg      <= mpa_pkg::MAG_RESET;
      position_error_alarm_level_reg <= mpa_pkg::ALARM_LEVEL_RESET;
    end else begin
      if (wr_off1) monitor_one_offset_reg <= setting_data[15:0];
      if (wr_off2) monitor_two_offset_reg <= setting_data[15:0];
      if (wr_mag) monitor_magnification_reg <= setting_data[15:0];
      if (wr_lvl) position_error_alarm_level_reg <= setting_data;
    end
  end

  // selection: defaults until first tick, then follow the ports
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_one_reg    <= mpa_pkg::SEL_ONE_RESET;
      sel_two_reg    <= mpa_pkg::SEL_TWO_RESET;
      sel_loaded_reg <= 1'b0;
    end else if (update_tick) begin
      sel_one_reg    <= monitor_one_signal_select;
      sel_two_reg    <= monitor_two_signal_select;
      sel_loaded_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // position error path
  wire signed [31:0] err_now = position_reference - actual_position;
  wire [31:0]        err_abs = err_now[31] ? 32'(-err_now) : err_now;
  wire               in_pos  = control_mode == mpa_pkg::MODE_POSITION;
  wire               over    = in_pos && (err_abs > position_error_alarm_level_reg);

  // signal selection, in mV; every source is an argument so the wires
  // re-evaluate when any source moves, not only when the select does
  wire signed [23:0] poserr_mv   = in_pos ? 24'(err_now) : 24'sh00_0000;
  wire signed [23:0] done_mv     = positioning_done ? mpa_pkg::DONE_MV : 24'sh00_0000;
  wire [3:0]         sel_one_now = sel_loaded_reg ? sel_one_reg : mpa_pkg::SEL_ONE_RESET;
  wire [3:0]         sel_two_now = sel_loaded_reg ? sel_two_reg : mpa_pkg::SEL_TWO_RESET;
  function automatic logic signed [23:0] pick(input logic [3:0]         s,
                                              input logic signed [23:0] spd,
                                              input logic signed [23:0] trq,
                                              input logic signed [23:0] pe,
                                              input logic signed [23:0] dn);
    case (s)
      mpa_pkg::SEL_SPEED:  pick = spd;
      mpa_pkg::SEL_TORQUE: pick = trq;
      mpa_pkg::SEL_POSERR: pick = pe;
      mpa_pkg::SEL_DONE:   pick = dn;
      default:             pick = 24'sh00_0000;
    endcase
  endfunction : pick
  wire signed [23:0] sig_one = pick(sel_one_now, motor_speed_mv, torque_ref_mv,
                                    poserr_mv, done_mv);
  wire signed [23:0] sig_two = pick(sel_two_now, motor_speed_mv, torque_ref_mv,
                                    poserr_mv, done_mv);

  // scaling; 48-bit products keep full precision before truncation
  wire signed [47:0] prod_one = 48'(sig_one) * 48'(monitor_magnification_reg)
                              / 48'(mpa_pkg::MAG_DIV);
  wire signed [47:0] prod_two = 48'(sig_two) * 48'(monitor_magnification_reg)
                              / 48'(mpa_pkg::MAG_DIV);
  wire signed [47:0] off_one  = 48'(monitor_one_offset_reg) * 48'(mpa_pkg::MV_PER_OFFSET_STEP);
  wire signed [47:0] off_two  = 48'(monitor_two_offset_reg) * 48'(mpa_pkg::MV_PER_OFFSET_STEP);
  wire signed [47:0] val_one  = -(prod_one + off_one);
  wire signed [47:0] val_two  = -(prod_two + off_two);
  wire signed [47:0] lim_pos  = 48'(mpa_pkg::LIN_MV);
  wire signed [47:0] lim_neg  = -48'(mpa_pkg::LIN_MV);
  // beyond +/-8 V the value is clamped and flagged non linear
  wire lin_one = val_one <= lim_pos && val_one >= lim_neg;
  wire lin_two = val_two <= lim_pos && val_two >= lim_neg;
  wire signed [23:0] out_one = lin_one ? 24'(val_one) : (val_one[47] ? -mpa_pkg::LIN_MV
                                                                      : mpa_pkg::LIN_MV);
  wire signed [23:0] out_two = lin_two ? 24'(val_two) : (val_two[47] ? -mpa_pkg::LIN_MV
                                                                      : mpa_pkg::LIN_MV);

  ////////////////////////////////////////////////////////////////////
  // per update tick registers; alarm latches until cleared
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      monitor_one_mv     <= 24'sh00_0000;
      monitor_two_mv     <= 24'sh00_0000;
      monitor_one_linear <= 1'b1;
      monitor_two_linear <= 1'b1;
      position_error     <= 32'sh0000_0000;
    end else if (update_tick) begin
      monitor_one_mv     <= out_one;
      monitor_two_mv     <= out_two;
      monitor_one_linear <= lin_one;
      monitor_two_linear <= lin_two;
      position_error     <= err_now;
    end
  end

  // set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      excess_position_error_alarm <= 1'b0;
      motor_stop                  <= 1'b0;
    end else begin
      if (update_tick && over) begin
        excess_position_error_alarm <= 1'b1;
        motor_stop                  <= 1'b1;
      end else if (alarm_clear) begin
        excess_position_error_alarm <= 1'b0;
        motor_stop                  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_over_tick;
    update_tick && over;
  endsequence
  chk_alarm_raise: assert property (@(posedge clk_sys) disable iff (rst)
    s_over_tick |=> excess_position_error_alarm) else $error("alarm not raised");
  chk_stop_follow: assert property (@(posedge clk_sys) disable iff (rst)
    excess_position_error_alarm |-> motor_stop) else $error("motor not stopped");
  chk_mode_gate: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(excess_position_error_alarm) |-> $past(control_mode) == mpa_pkg::MODE_POSITION)
    else $error("alarm outside position mode");
  chk_err_calc: assert property (@(posedge clk_sys) disable iff (rst)
    update_tick |=> position_error == $past(position_reference) - $past(actual_position))
    else $error("position error wrong");
  chk_lin_span: assert property (@(posedge clk_sys) disable iff (rst)
    monitor_one_mv <= mpa_pkg::LIN_MV && monitor_one_mv >= -mpa_pkg::LIN_MV)
    else $error("monitor one out of span");
  chk_mon_update: assert property (@(posedge clk_sys) disable iff (rst)
    update_tick && lin_two |=> monitor_two_mv == $past(out_two))
    else $error("monitor two stale");
  chk_lvl_range: assert property (@(posedge clk_sys) disable iff (rst)
    position_error_alarm_level_reg >= mpa_pkg::ALARM_LEVEL_MIN
    && position_error_alarm_level_reg <= mpa_pkg::ALARM_LEVEL_MAX)
    else $error("alarm level out of range");
  chk_off_range: assert property (@(posedge clk_sys) disable iff (rst)
    monitor_one_offset_reg >= mpa_pkg::SET_MIN && monitor_one_offset_reg <= mpa_pkg::SET_MAX
    && monitor_two_offset_reg >= mpa_pkg::SET_MIN
    && monitor_two_offset_reg <= mpa_pkg::SET_MAX) else $error("offset out of range");
  chk_mag_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_mag |=> monitor_magnification_reg == 16'($past(setting_data)))
    else $error("magnification not taken");
  // writes land one cycle later; out of range data never reaches a setting
  chk_off1_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_off1 |=> monitor_one_offset_reg == 16'($past(setting_data)))
    else $error("offset one not taken");
  chk_off2_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_off2 |=> monitor_two_offset_reg == 16'($past(setting_data)))
    else $error("offset two not taken");
  chk_lvl_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_lvl |=> position_error_alarm_level_reg == $past(setting_data))
    else $error("alarm level not taken");
  chk_lin_two: assert property (@(posedge clk_sys) disable iff (rst)
    monitor_two_mv <= mpa_pkg::LIN_MV && monitor_two_mv >= -mpa_pkg::LIN_MV)
    else $error("monitor two out of span");
  chk_clamp_two: assert property (@(posedge clk_sys) disable iff (rst)
    update_tick && !lin_two |=> !monitor_two_linear
    && (monitor_two_mv == mpa_pkg::LIN_MV || monitor_two_mv == -mpa_pkg::LIN_MV))
    else $error("monitor two not clamped");
  chk_done_zero: assert property (@(posedge clk_sys) disable iff (rst)
    update_tick && sel_two_now == mpa_pkg::SEL_DONE && !positioning_done
    && monitor_two_offset_reg == mpa_pkg::OFFSET_RESET |=> monitor_two_mv == 24'sh00_0000)
    else $error("idle completion not zero");
  // alarm and stop move together; only a clear without a new over tick drops them
  sequence s_clear_only;
    alarm_clear && !(update_tick && over);
  endsequence
  chk_stop_match: assert property (@(posedge clk_sys) disable iff (rst)
    motor_stop == excess_position_error_alarm) else $error("stop differs from alarm");
  chk_alarm_hold: assert property (@(posedge clk_sys) disable iff (rst)
    excess_position_error_alarm && !alarm_clear |=> excess_position_error_alarm)
    else $error("alarm dropped");
  chk_clear_drop: assert property (@(posedge clk_sys) disable iff (rst)
    s_clear_only |=> !excess_position_error_alarm && !motor_stop)
    else $error("alarm not cleared");
  chk_mode_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    update_tick && !in_pos && !excess_position_error_alarm |=> !excess_position_error_alarm)
    else $error("alarm raised outside position mode");
endmodule : mpa_top
`default_nettype wire

// >>> rtl/mpa_pkg.sv
// constants for monitor scaling and position error alarm
// Behaviour
// - each monitor output is minus (selected signal times magnification plus offset)
// - monitor one offset signed -10000..10000 in 0.1 V, reset zero, immediate
// - monitor two offset signed -10000..10000 in 0.1 V, reset zero, immediate
// - magnification signed -10000..10000 in 0.01 steps, applied immediately
// - default: channel one torque reference, channel two motor speed
// - outputs only linear within plus or minus eight volts
// - position error alarm only active in position control mode
// - position error is position reference minus actual position
// - alarm level 1..1073741823, reset 5242880, effective immediately
// - alarm raised when position error exceeds the alarm level
// - once alarm is raised the motor is stopped
// - positioning completed selection gives 5 V, else 0 V
package mpa_pkg;
  localparam int SETTING_W     = 16;
  localparam int POS_W         = 32;
  localparam int MON_W         = 24;
  localparam int SEL_W         = 4;
  // settings range, magnification in 0.01 steps, offsets in 0.1 V (= 100 mV)
  localparam logic signed [15:0] SET_MAX = 16'sh2710;
  localparam logic signed [15:0] SET_MIN = -16'sh2710;
  localparam logic signed [15:0] OFFSET_RESET = 16'sh0000;
  localparam logic signed [15:0] MAG_RESET    = 16'sh0064;
  localparam logic [31:0] ALARM_LEVEL_RESET = 32'h0050_0000;
  localparam logic [31:0] ALARM_LEVEL_MAX   = 32'h3FFF_FFFF;
  localparam logic [31:0] ALARM_LEVEL_MIN   = 32'h0000_0001;
  // signal selections
  localparam logic [3:0] SEL_SPEED  = 4'h0;
  localparam logic [3:0] SEL_TORQUE = 4'h2;
  localparam logic [3:0] SEL_POSERR = 4'h3;
  localparam logic [3:0] SEL_DONE   = 4'h8;
  localparam logic [3:0] SEL_ONE_RESET = SEL_TORQUE;
  localparam logic [3:0] SEL_TWO_RESET = SEL_SPEED;
  // selected signals in mV; 5 V for completion, +/-8 V linear span
  localparam logic signed [23:0] DONE_MV = 24'sh00_1388;
  localparam logic signed [23:0] LIN_MV  = 24'sh00_1F40;
  localparam int MV_PER_OFFSET_STEP = 100;
  localparam int MAG_DIV = 100;
  // control modes
  localparam logic [1:0] MODE_SPEED    = 2'h0;
  localparam logic [1:0] MODE_POSITION = 2'h1;
  localparam logic [1:0] MODE_TORQUE   = 2'h2;
endpackage : mpa_pkg

// >>> tb/mpa_host_model.sv
// host reference source and encoder feedback model
`timescale 1ns/1ps
`default_nettype none
module mpa_host_model (
  input  wire logic               clk_sys,
  input  wire logic signed [31:0] target,
  input  wire logic signed [31:0] lag,
  output var  logic signed [31:0] position_reference,
  output var  logic signed [31:0] actual_position
);
  // motor trails the command by lag; lag sets the error seen by the drive
  always_ff @(posedge clk_sys) begin
    position_reference <= target;
    actual_position    <= target - lag;
  end
endmodule : mpa_host_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for monitor scaling and position error alarm
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0, rst = 1'b1, update_tick = 1'b0, positioning_done = 1'b0;
  logic setting_write = 1'b0, alarm_clear = 1'b0;
  logic [1:0] control_mode = 2'h0, setting_addr = 2'h0;
  logic [3:0] sel_one = 4'h2, sel_two = 4'h0;
  logic signed [31:0] setting_data = 32'sh0000_0000, target = 32'sh0000_1000, lag = 32'sh0;
  logic signed [31:0] position_reference, actual_position, position_error;
  logic signed [23:0] torque_mv = 24'sh00_03E8, speed_mv = 24'sh00_07D0, mon_one, mon_two;
  logic lin_one, lin_two, alarm, motor_stop;
  int n_fail = 0, tests_run = 0, cycles = 0;
  always #4 clk_sys = ~clk_sys;
  mpa_host_model host (.clk_sys(clk_sys), .target(target), .lag(lag),
    .position_reference(position_reference), .actual_position(actual_position));
  mpa_top uut (.clk_sys(clk_sys), .rst(rst), .update_tick(update_tick),
    .control_mode(control_mode), .position_reference(position_reference),
    .actual_position(actual_position), .torque_ref_mv(torque_mv), .motor_speed_mv(speed_mv),
    .positioning_done(positioning_done), .monitor_one_signal_select(sel_one),
    .monitor_two_signal_select(sel_two), .setting_write(setting_write),
    .setting_addr(setting_addr), .setting_data(setting_data), .alarm_clear(alarm_clear),
    .monitor_one_mv(mon_one), .monitor_two_mv(mon_two), .monitor_one_linear(lin_one),
    .monitor_two_linear(lin_two), .position_error(position_error),
    .excess_position_error_alarm(alarm), .motor_stop(motor_stop));
  ////////////////////////////////////////////////////////////////////////////
  // access tasks and reference arithmetic
  task automatic chk(input string what, input logic signed [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk
  task automatic put(input logic [1:0] a, input logic signed [31:0] d);
    @(posedge clk_sys) begin setting_write <= 1'b1; setting_addr <= a; setting_data <= d; end
    @(posedge clk_sys) setting_write <= 1'b0;
  endtask : put
  // tick, then let the registered outputs settle before sampling
  task automatic tick();
    @(posedge clk_sys) update_tick <= 1'b1;
    @(posedge clk_sys) update_tick <= 1'b0;
    @(negedge clk_sys);
  endtask : tick
  // truncating divide then clamp to the linear span
  function automatic logic signed [31:0] expv(input int sig, mag, off);
    int v;
    v = -((sig * mag) / 100 + off * 100);
    if (v > 8000) v = 8000;
    if (v < -8000) v = -8000;
    return v;
  endfunction : expv
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // hang guard, far above the roughly 55 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    tick();
    chk("mon_one", mon_one, expv(1000, 100, 0));
    chk("mon_two", mon_two, expv(2000, 100, 0));
    $display("test defaults done");
    put(2'h0, 32'sd5);
    put(2'h1, -32'sd3);
    tick();
    chk("mon_one", mon_one, expv(1000, 100, 5));
    chk("mon_two", mon_two, expv(2000, 100, -3));
    put(2'h2, 32'sd250);
    put(2'h2, 32'sd10001);
    put(2'h0, -32'sd10001);
    tick();
    chk("mon_one", mon_one, expv(1000, 250, 5));
    // a selection is latched at one tick and used from the next one
    @(posedge clk_sys) begin
      speed_mv         <= -24'sd9000;
      sel_two          <= 4'h8;
      positioning_done <= 1'b1;
    end
    put(2'h1, 32'sd0);
    tick();
    chk("mon_two", mon_two, expv(-9000, 250, 0));
    chk("lin_two", lin_two, 32'sd0);
    chk("lin_one", lin_one, 32'sd1);
    put(2'h2, -32'sd50);
    tick();
    chk("mon_two", mon_two, expv(5000, -50, 0));
    @(posedge clk_sys) positioning_done <= 1'b0;
    tick();
    chk("mon_two_idle", mon_two, expv(0, -50, 0));
    $display("test monitor scaling done");
    put(2'h3, 32'sd10);
    @(posedge clk_sys) lag <= 32'sd11;
    tick();
    chk("alarm_speed", alarm, 32'sd0);
    @(posedge clk_sys) begin
      control_mode <= 2'h1;
      sel_one      <= 4'h3;
      lag          <= 32'sd10;
    end
    tick();
    chk("pos_err", position_error, 32'sd10);
    chk("alarm_eq", alarm, 32'sd0);
    @(posedge clk_sys) lag <= 32'sd11;
    tick();
    chk("pos_err", position_error, 32'sd11);
    chk("alarm_over", alarm, 32'sd1);
    chk("stop", motor_stop, 32'sd1);
    chk("mon_one_err", mon_one, expv(11, -50, 5));
    @(posedge clk_sys) begin
      control_mode <= 2'h2;
      alarm_clear  <= 1'b1;
    end
    @(posedge clk_sys) alarm_clear <= 1'b0;
    tick();
    chk("alarm_torque", alarm, 32'sd0);
    chk("stop_clear", motor_stop, 32'sd0);
    chk("mon_one_torque", mon_one, expv(0, -50, 5));
    $display("test position error alarm done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
